// *** mbsda_slave.sv ***
`timescale 1ns/1ns
`default_nettype none

module mbsda_slave (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] dev_addr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_slave,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_arg,
  input wire logic [15:0] req_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_word,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_func,
  output logic [15:0] rsp_word,
  output logic rsp_last,
  output logic rsp_exc,
  input wire logic upd_valid,
  input wire logic [15:0] upd_addr,
  input wire logic [31:0] upd_value,
  input wire logic upd_lead,
  input wire logic [6:0] cfg_rd_index,
  output logic [15:0] cfg_rd_word
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  localparam int METER_WORDS_L = mbsda_pkg::METER_WORDS;
  localparam int CFG_WORDS_L = mbsda_pkg::CFG_WORDS;
  logic [15:0] meter_mem [METER_WORDS_L];
  logic [15:0] cfg_mem [CFG_WORDS_L];

  mbsda_pkg::mbsda_state_type state_reg;
  logic [7:0] func_reg, exc_reg;
  logic [15:0] base_reg, idx_reg, total_reg, echo0_reg, echo1_reg, word_reg;
  logic read_reg, quiet_reg;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic mbsda_pkg::mbsda_region_type region_of(input logic [15:0] a);
    if (a >= mbsda_pkg::VI_ADDR && a < mbsda_pkg::VI_ADDR + mbsda_pkg::VI_WORDS) begin
      return mbsda_pkg::RG_VI;
    end else if (a >= mbsda_pkg::PW_ADDR && a < mbsda_pkg::PW_ADDR + mbsda_pkg::PW_WORDS) begin
      return mbsda_pkg::RG_PW;
    end else if (a >= mbsda_pkg::CFG_ADDR && a < mbsda_pkg::CFG_ADDR + mbsda_pkg::CFG_ELEMS) begin
      return mbsda_pkg::RG_CFG;
    end else if (a >= mbsda_pkg::ST_ADDR && a < mbsda_pkg::ST_ADDR + mbsda_pkg::ST_ELEMS) begin
      return mbsda_pkg::RG_ST;
    end
    return mbsda_pkg::RG_NONE;
  endfunction

  // Meter words of all three read-only tables share one array
  function automatic logic [5:0] meter_index(input logic [15:0] a);
    logic [15:0] off;
    unique case (region_of(a))
      mbsda_pkg::RG_VI: off = a - mbsda_pkg::VI_ADDR + 16'(mbsda_pkg::VI_MEM_BASE);
      mbsda_pkg::RG_PW: off = a - mbsda_pkg::PW_ADDR + 16'(mbsda_pkg::PW_MEM_BASE);
      mbsda_pkg::RG_ST: off = a - mbsda_pkg::ST_ADDR + 16'(mbsda_pkg::ST_MEM_BASE);
      default: off = 16'h0000;
    endcase
    return off[5:0];
  endfunction

  function automatic logic [6:0] cfg_index(input logic [15:0] a);
    logic [15:0] off;
    off = a - mbsda_pkg::CFG_ADDR;
    return off[6:0];
  endfunction

  // ****************************************************************
  // Request classification
  // ****************************************************************
  logic accept, is_ours, is_bcast, is_write, is_read;
  logic [15:0] last_addr;
  logic range_ok, qty_rd_ok, qty_wr_ok;
  logic [7:0] req_exc;
  mbsda_pkg::mbsda_region_type first_rg;

  assign req_ready = (state_reg == mbsda_pkg::ST_IDLE);
  assign accept = req_valid && req_ready;
  assign is_ours = (req_slave == dev_addr) && (req_slave != mbsda_pkg::BCAST_ADDR);
  assign is_bcast = (req_slave == mbsda_pkg::BCAST_ADDR);
  assign is_write = (req_func == mbsda_pkg::FC_WR_SINGLE) || (req_func == mbsda_pkg::FC_WR_MULTI);
  assign is_read = (req_func == mbsda_pkg::FC_RD_HOLD) || (req_func == mbsda_pkg::FC_RD_INPUT)
                   || (req_func == mbsda_pkg::FC_RD_SPECIAL);
  assign last_addr = req_addr + req_arg - 16'h0001;
  assign first_rg = region_of(req_addr);
  assign range_ok = (first_rg != mbsda_pkg::RG_NONE) && (region_of(last_addr) == first_rg)
                    && (last_addr >= req_addr);
  assign qty_rd_ok = (req_arg != 16'h0000) && (req_arg <= mbsda_pkg::MAX_RD_QTY);
  assign qty_wr_ok = (req_arg != 16'h0000) && (req_arg <= mbsda_pkg::MAX_WR_QTY);

  always_comb begin
    req_exc = mbsda_pkg::EXC_NONE;
    case (req_func)
      mbsda_pkg::FC_RD_HOLD, mbsda_pkg::FC_RD_INPUT, mbsda_pkg::FC_RD_SPECIAL: begin
        if (!qty_rd_ok) begin
          req_exc = mbsda_pkg::EXC_ILL_VALUE;
        end else if (!range_ok) begin
          req_exc = mbsda_pkg::EXC_ILL_ADDR;
        end
      end
      mbsda_pkg::FC_WR_SINGLE: begin
        if (first_rg != mbsda_pkg::RG_CFG) begin
          req_exc = mbsda_pkg::EXC_ILL_ADDR;
        end
      end
      mbsda_pkg::FC_WR_MULTI: begin
        if (!qty_wr_ok) begin
          req_exc = mbsda_pkg::EXC_ILL_VALUE;
        end else if (!range_ok || first_rg != mbsda_pkg::RG_CFG) begin
          req_exc = mbsda_pkg::EXC_ILL_ADDR;
        end
      end
      mbsda_pkg::FC_DIAG: begin
        if (req_arg != mbsda_pkg::DIAG_SUB_ECHO) begin
          req_exc = mbsda_pkg::EXC_ILL_FUNC;
        end
      end
      default: req_exc = mbsda_pkg::EXC_ILL_FUNC;
    endcase
  end

  // ****************************************************************
  // Word fetch for the reply path
  // ****************************************************************
  logic [15:0] fetch_addr, fetch_word;

  assign fetch_addr = (state_reg == mbsda_pkg::ST_IDLE) ? req_addr
                      : base_reg + idx_reg + 16'h0001;

  // All three read codes share this path, so 03, 04 and 42 see the same words
  always_comb begin
    fetch_word = mbsda_pkg::WORD_RESET;
    if (region_of(fetch_addr) == mbsda_pkg::RG_CFG) begin
      fetch_word = cfg_mem[cfg_index(fetch_addr)];
    end else if (region_of(fetch_addr) != mbsda_pkg::RG_NONE) begin
      fetch_word = meter_mem[meter_index(fetch_addr)];
    end
  end

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  logic take, wr_done;

  // Foreign slave addresses and broadcast reads are dropped silently
  assign take = accept && (is_ours || (is_bcast && is_write));
  assign wr_done = wr_valid && (idx_reg == total_reg - 16'h0001);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= mbsda_pkg::ST_IDLE;
      func_reg <= 8'h00;
      exc_reg <= mbsda_pkg::EXC_NONE;
      base_reg <= 16'h0000;
      idx_reg <= 16'h0000;
      total_reg <= 16'h0000;
      echo0_reg <= 16'h0000;
      echo1_reg <= 16'h0000;
      word_reg <= 16'h0000;
      read_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        mbsda_pkg::ST_IDLE: begin
          if (take) begin
            func_reg <= req_func;
            exc_reg <= req_exc;
            base_reg <= req_addr;
            idx_reg <= 16'h0000;
            read_reg <= is_read && (req_exc == mbsda_pkg::EXC_NONE);
            quiet_reg <= is_bcast;
            echo0_reg <= (req_func == mbsda_pkg::FC_DIAG) ? req_arg : req_addr;
            echo1_reg <= (req_func == mbsda_pkg::FC_DIAG) ? req_data : req_arg;
            if (req_func == mbsda_pkg::FC_WR_MULTI && req_exc != mbsda_pkg::EXC_ILL_VALUE) begin
              // Words are drained even for a bad address to keep framing aligned
              total_reg <= req_arg;
              state_reg <= mbsda_pkg::ST_COLLECT;
            end else if (is_bcast) begin
              state_reg <= mbsda_pkg::ST_IDLE;
            end else begin
              state_reg <= mbsda_pkg::ST_REPLY;
              if (req_exc != mbsda_pkg::EXC_NONE) begin
                total_reg <= 16'h0001;
                word_reg <= {8'h00, req_exc};
              end else if (is_read) begin
                total_reg <= req_arg;
                word_reg <= fetch_word;
              end else begin
                total_reg <= 16'h0002;
                word_reg <= (req_func == mbsda_pkg::FC_DIAG) ? req_arg : req_addr;
              end
            end
          end
        end
        mbsda_pkg::ST_COLLECT: begin
          if (wr_valid) begin
            idx_reg <= idx_reg + 16'h0001;
            if (wr_done) begin
              idx_reg <= 16'h0000;
              total_reg <= (exc_reg != mbsda_pkg::EXC_NONE) ? 16'h0001 : 16'h0002;
              word_reg <= (exc_reg != mbsda_pkg::EXC_NONE) ? {8'h00, exc_reg} : echo0_reg;
              state_reg <= quiet_reg ? mbsda_pkg::ST_IDLE : mbsda_pkg::ST_REPLY;
            end
          end
        end
        mbsda_pkg::ST_REPLY: begin
          if (rsp_ready) begin
            if (rsp_last) begin
              state_reg <= mbsda_pkg::ST_IDLE;
            end else begin
              idx_reg <= idx_reg + 16'h0001;
              word_reg <= read_reg ? fetch_word : echo1_reg;
            end
          end
        end
      endcase
    end
  end

  assign wr_ready = (state_reg == mbsda_pkg::ST_COLLECT);
  assign rsp_valid = (state_reg == mbsda_pkg::ST_REPLY);
  assign rsp_word = word_reg;
  assign rsp_exc = (exc_reg != mbsda_pkg::EXC_NONE);
  assign rsp_func = rsp_exc ? (func_reg | mbsda_pkg::EXC_FLAG) : func_reg;
  assign rsp_last = rsp_valid && (idx_reg == total_reg - 16'h0001);

  // ****************************************************************
  // Configuration table writes
  // ****************************************************************
  logic cfg_we;
  logic [6:0] cfg_widx;
  logic [15:0] cfg_wdata;

  assign cfg_we = (take && req_func == mbsda_pkg::FC_WR_SINGLE
                   && req_exc == mbsda_pkg::EXC_NONE)
                  || (wr_ready && wr_valid && exc_reg == mbsda_pkg::EXC_NONE);
  assign cfg_widx = wr_ready ? cfg_index(base_reg + idx_reg) : cfg_index(req_addr);
  assign cfg_wdata = wr_ready ? wr_word : req_arg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS_L; i++) begin
        cfg_mem[i] <= mbsda_pkg::WORD_RESET;
      end
    end else if (cfg_we) begin
      cfg_mem[cfg_widx] <= cfg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rd_word <= mbsda_pkg::WORD_RESET;
    end else begin
      cfg_rd_word <= cfg_mem[cfg_rd_index];
    end
  end

  // ****************************************************************
  // Metering updates, low word first
  // ****************************************************************
  logic upd_ok, upd_pf;
  logic [5:0] upd_idx;
  logic [15:0] upd_elem;
  logic [31:0] upd_real;

  assign upd_ok = upd_valid && (region_of(upd_addr) != mbsda_pkg::RG_NONE)
                  && (region_of(upd_addr) != mbsda_pkg::RG_CFG);
  assign upd_idx = meter_index(upd_addr);
  assign upd_elem = (upd_addr - mbsda_pkg::PW_ADDR) >> 1;
  assign upd_pf = (region_of(upd_addr) == mbsda_pkg::RG_PW)
                  && (upd_elem >= mbsda_pkg::PF_FIRST_ELEM) && (upd_elem <= mbsda_pkg::PF_LAST_ELEM);

  // Sign of a power factor follows the leading flag, not the raw value
  always_comb begin
    upd_real = upd_value;
    if (upd_pf) begin
      upd_real[mbsda_pkg::REAL_SIGN_BIT] = upd_lead;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < METER_WORDS_L; i++) begin
        meter_mem[i] <= mbsda_pkg::WORD_RESET;
      end
    end else if (upd_ok) begin
      meter_mem[upd_idx] <= upd_real[15:0];
      meter_mem[6'(upd_idx + 6'h01)] <= upd_real[31:16];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  bad_func_a: assert property (take && is_ours && req_exc == mbsda_pkg::EXC_ILL_FUNC
    |=> rsp_valid && rsp_exc && rsp_word == 16'h0001 && rsp_func == ($past(req_func) | 8'h80))
    else $error("unsupported code not answered with exception");
  ro_write_a: assert property (take && is_ours && req_func == mbsda_pkg::FC_WR_SINGLE
    && first_rg != mbsda_pkg::RG_CFG |=> rsp_valid && rsp_word == 16'h0002)
    else $error("read-only write not refused");
  bcast_quiet_a: assert property (take && is_bcast
    && req_func == mbsda_pkg::FC_WR_SINGLE |=> !rsp_valid && req_ready)
    else $error("reply sent for broadcast write");
  single_write_a: assert property (cfg_we && !wr_ready
    |=> cfg_mem[$past(cfg_widx)] == $past(req_arg))
    else $error("single write not stored");
  multi_write_a: assert property (wr_ready && wr_valid && exc_reg == mbsda_pkg::EXC_NONE
    |=> cfg_mem[$past(cfg_widx)] == $past(wr_word))
    else $error("multiple write word not stored");
  read_data_a: assert property (take && is_ours && is_read
    && req_exc == mbsda_pkg::EXC_NONE |=> rsp_valid && !rsp_exc && rsp_word == $past(fetch_word)
    && total_reg == $past(req_arg))
    else $error("read reply word or count wrong");
  diag_sub_a: assert property (take && is_ours && req_func == mbsda_pkg::FC_DIAG
    && req_arg != 16'h0000 |=> rsp_func == 8'h88 ##0 rsp_last)
    else $error("bad diagnostic subfunction accepted");
  pf_sign_a: assert property (upd_ok && upd_pf
    |=> meter_mem[$past(upd_idx) + 6'h01][15] == $past(upd_lead))
    else $error("power factor sign not from leading flag");
  low_word_a: assert property (upd_ok
    |=> meter_mem[$past(upd_idx)] == $past(upd_value[15:0]))
    else $error("low word not at lowest address");
  vi_map_a: assert property (take && is_ours && req_func == mbsda_pkg::FC_RD_INPUT
    && req_addr == 16'h0050 && req_arg == 16'h0018 |=> !rsp_exc)
    else $error("voltage table not at its frame address");

  read_cov: cover property (take && is_ours && is_read ##1 (rsp_valid && rsp_last && rsp_ready));
  bcast_cov: cover property (take && is_bcast && req_func == mbsda_pkg::FC_WR_MULTI);
  multi_cov: cover property (wr_ready && wr_done ##1 rsp_valid);
  exc_cov: cover property (rsp_valid && rsp_exc && rsp_ready);

endmodule

`default_nettype wire

// *** mbsda_pkg.sv ***
package mbsda_pkg;

  // ****************************************************************
  // Function codes and reply codes
  // ****************************************************************
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_RD_SPECIAL = 8'h42;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [15:0] DIAG_SUB_ECHO = 16'h0000;
  localparam logic [15:0] MAX_RD_QTY = 16'h007D;
  localparam logic [15:0] MAX_WR_QTY = 16'h007B;

  // ****************************************************************
  // Table map: six-digit table addresses and frame word addresses
  // ****************************************************************
  localparam logic [31:0] TABLE_BASE = 32'h0004_93E1;
  localparam logic [31:0] VI_TABLE = 32'h0004_9431;
  localparam logic [31:0] PW_TABLE = 32'h0004_9449;
  localparam logic [31:0] CFG_TABLE = 32'h0004_A3E1;
  localparam logic [31:0] ST_TABLE = 32'h0004_D3E1;
  localparam logic [15:0] VI_ADDR = 16'(VI_TABLE - TABLE_BASE);
  localparam logic [15:0] PW_ADDR = 16'(PW_TABLE - TABLE_BASE);
  localparam logic [15:0] CFG_ADDR = 16'(CFG_TABLE - TABLE_BASE);
  localparam logic [15:0] ST_ADDR = 16'(ST_TABLE - TABLE_BASE);
  localparam logic [15:0] VI_ELEMS = 16'h000C;
  localparam logic [15:0] PW_ELEMS = 16'h0012;
  localparam logic [15:0] CFG_ELEMS = 16'h004F;
  localparam logic [15:0] ST_ELEMS = 16'h0002;
  localparam logic [15:0] REAL_WORDS = 16'h0002;
  localparam logic [15:0] VI_WORDS = 16'(VI_ELEMS * REAL_WORDS);
  localparam logic [15:0] PW_WORDS = 16'(PW_ELEMS * REAL_WORDS);
  localparam int METER_WORDS = 62;
  localparam int CFG_WORDS = 79;
  localparam logic [5:0] VI_MEM_BASE = 6'h00;
  localparam logic [5:0] PW_MEM_BASE = 6'h18;
  localparam logic [5:0] ST_MEM_BASE = 6'h3C;
  localparam logic [15:0] PF_FIRST_ELEM = 16'h000C;
  localparam logic [15:0] PF_LAST_ELEM = 16'h000F;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int REAL_SIGN_BIT = 31;
  localparam int REAL_EXP_BIAS = 127;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COLLECT = 2'b01,
    ST_REPLY = 2'b10
  } mbsda_state_type;

  typedef enum logic [2:0] {
    RG_NONE = 3'b000,
    RG_VI = 3'b001,
    RG_PW = 3'b010,
    RG_CFG = 3'b011,
    RG_ST = 3'b100
  } mbsda_region_type;

endpackage

// *** mbsda_master.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Master side of the request and reply link
// ****************************************
module mbsda_master (
  input wire logic mclk,
  input wire logic req_ready,
  output logic req_valid,
  output logic [7:0] req_slave,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_arg,
  output logic [15:0] req_data,
  input wire logic wr_ready,
  output logic wr_valid,
  output logic [15:0] wr_word,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_func,
  input wire logic [15:0] rsp_word,
  input wire logic rsp_last,
  input wire logic rsp_exc
);
  initial begin
    req_valid = 1'b0;
    req_slave = 8'h00;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_arg = 16'h0000;
    req_data = 16'h0000;
    wr_valid = 1'b0;
    wr_word = 16'h0000;
    rsp_ready = 1'b0;
  end

  // Released address, argument and data fields show the inverse so a stale value is never mistaken for data
  task automatic xfer(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
      input logic [15:0] ag, input logic [15:0] dt, input logic [15:0] wq[$], input bit slow,
      input int lim, output logic [15:0] q[$], output logic [7:0] f, output logic e,
      output bit ok);
    int n;
    q = {};
    f = 8'h00;
    e = 1'b0;
    ok = 1'b0;
    @(negedge mclk);
    req_valid = 1'b1;
    req_slave = sl;
    req_func = fn;
    req_addr = ad;
    req_arg = ag;
    req_data = dt;
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      if (req_ready === 1'b1) break;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    req_addr = ~ad;
    req_arg = ~ag;
    req_data = ~dt;
    if (fn == mbsda_pkg::FC_WR_MULTI) begin
      foreach (wq[k]) begin
        wr_valid = 1'b1;
        wr_word = wq[k];
        for (n = 0; n < lim; n++) begin
          @(posedge mclk);
          if (wr_ready === 1'b1) break;
        end
        @(negedge mclk);
      end
      // Stale word shows its inverse once the burst is over
      wr_word = ~wr_word;
    end
    wr_valid = 1'b0;
    for (n = 0; n < lim; n++) begin
      rsp_ready = slow ? 1'($urandom_range(1)) : 1'b1;
      @(posedge mclk);
      if (rsp_valid === 1'b1 && rsp_ready) begin
        q.push_back(rsp_word);
        f = rsp_func;
        e = rsp_exc;
        if (rsp_last === 1'b1) begin
          ok = 1'b1;
          break;
        end
      end
      @(negedge mclk);
    end
    @(negedge mclk);
    rsp_ready = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic mclk, rst, req_valid, req_ready, wr_valid, wr_ready, rsp_valid, rsp_ready;
  logic rsp_last, rsp_exc, upd_valid, upd_lead, e;
  logic [7:0] dev_addr, req_slave, req_func, rsp_func, f;
  logic [15:0] req_addr, req_arg, req_data, wr_word, rsp_word, upd_addr, cfg_rd_word;
  logic [31:0] upd_value;
  logic [6:0] cfg_rd_index;
  logic [15:0] mdl [0:65535];
  logic [15:0] q[$], wq[$];
  int num_errors, checks, i;
  bit slow;
  localparam int BASE = 300001;
  localparam logic [15:0] A_VI = 16'(300081 - BASE);
  localparam logic [15:0] A_PW = 16'(300105 - BASE);
  localparam logic [15:0] A_CFG = 16'(304097 - BASE);
  localparam logic [15:0] A_ST = 16'(316385 - BASE);

  mbsda_slave i_mbsda_slave (.mclk, .rst, .dev_addr, .req_valid, .req_ready, .req_slave,
    .req_func, .req_addr, .req_arg, .req_data, .wr_valid, .wr_ready, .wr_word, .rsp_valid,
    .rsp_ready, .rsp_func, .rsp_word, .rsp_last, .rsp_exc, .upd_valid, .upd_addr,
    .upd_value, .upd_lead, .cfg_rd_index, .cfg_rd_word);
  mbsda_master i_mbsda_master (.mclk, .req_ready, .req_valid, .req_slave, .req_func,
    .req_addr, .req_arg, .req_data, .wr_ready, .wr_valid, .wr_word, .rsp_valid, .rsp_ready,
    .rsp_func, .rsp_word, .rsp_last, .rsp_exc);

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic end_sim();
    $display("mismatches %0d of %0d comparisons", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
      input logic [15:0] ag, input logic [15:0] dt, input bit want);
    bit ok;
    i_mbsda_master.xfer(sl, fn, ad, ag, dt, wq, slow, want ? 1000 : 30, q, f, e, ok);
    if (want && !ok) begin
      num_errors++;
      end_sim();
    end
    if (!want) cmp_word(16'(q.size()), 16'h0000);
  endtask

  task automatic chk(input logic [7:0] fn, input logic [15:0] x[$]);
    cmp_word({8'h00, f}, {8'h00, fn});
    cmp_bit(e, 1'b0);
    cmp_word(16'(q.size()), 16'(x.size()));
    foreach (x[k]) if (k < q.size()) cmp_word(q[k], x[k]);
  endtask

  // ****************************************
  // Transactions against the reference model
  // ****************************************
  task automatic rd(input logic [7:0] fn, input logic [15:0] ad, input int n);
    logic [15:0] x[$];
    for (int k = 0; k < n; k++) x.push_back(mdl[16'(ad + k)]);
    go(dev_addr, fn, ad, 16'(n), 16'h0000, 1'b1);
    chk(fn, x);
  endtask

  task automatic wr(input logic [7:0] sl, input logic [15:0] ad, input int n);
    logic [7:0] fn;
    wq = {};
    for (int k = 0; k < n; k++) begin
      wq.push_back(16'($urandom));
      mdl[16'(ad + k)] = wq[k];
    end
    fn = (n == 1) ? mbsda_pkg::FC_WR_SINGLE : mbsda_pkg::FC_WR_MULTI;
    go(sl, fn, ad, (n == 1) ? wq[0] : 16'(n), 16'h0000, sl != 8'h00);
    if (sl != 8'h00) chk(fn, {ad, (n == 1) ? wq[0] : 16'(n)});
  endtask

  task automatic exc(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] ag,
      input logic [7:0] code);
    wq = {};
    repeat (int'(ag)) wq.push_back(16'($urandom));
    go(dev_addr, fn, ad, ag, 16'h1234, 1'b1);
    cmp_word({8'h00, f}, {8'h00, fn | mbsda_pkg::EXC_FLAG});
    cmp_bit(e, 1'b1);
    cmp_word(16'(q.size()), 16'h0001);
    cmp_word({8'h00, q[0][7:0]}, {8'h00, code});
  endtask

  // Back-to-back pulses: the strobe stays up until the caller lowers it
  task automatic upd(input logic [15:0] ad, input logic [31:0] v, input logic ld);
    @(negedge mclk);
    upd_valid = 1'b1;
    upd_addr = ad;
    upd_value = v;
    upd_lead = ld;
    if (ad >= A_PW + 16'h0018 && ad < A_PW + 16'h0020) v[31] = ld;
    if (ad != A_CFG) begin
      mdl[ad] = v[15:0];
      mdl[16'(ad + 1)] = v[31:16];
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    #300000;
    num_errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    dev_addr = 8'h01;
    upd_valid = 1'b0;
    upd_addr = 16'h0000;
    upd_value = 32'h0000_0000;
    upd_lead = 1'b0;
    cfg_rd_index = 7'h00;
    slow = 1'b0;
    num_errors = 0;
    checks = 0;
    for (i = 0; i < 65536; i++) mdl[i] = 16'h0000;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    void'($urandom(32'h022a));
    dev_addr = 8'($urandom_range(247, 1));
    cmp_bit(req_ready, 1'b1);
    cmp_bit(rsp_valid, 1'b0);
    cmp_word(cfg_rd_word, 16'h0000);
    for (i = 0; i < 12; i++) upd(A_VI + 16'(2 * i), $urandom, 1'($urandom));
    for (i = 0; i < 18; i++) upd(A_PW + 16'(2 * i), $urandom, 1'($urandom));
    upd(A_VI, 32'h4366_0000, 1'b0);
    upd(A_PW + 16'h0018, 32'h3F80_0000, 1'b1);
    upd(A_ST, $urandom, 1'b0);
    upd(A_CFG, $urandom, 1'b0);
    @(negedge mclk);
    upd_valid = 1'b0;
    rd(mbsda_pkg::FC_RD_HOLD, A_VI, 24);
    cmp_word({8'h00, q[1][14:7]}, 16'(127 + 7));
    cmp_bit(q[1][15], 1'b0);
    slow = 1'b1;
    rd(mbsda_pkg::FC_RD_INPUT, A_VI, 24);
    rd(mbsda_pkg::FC_RD_SPECIAL, A_PW, 36);
    rd(mbsda_pkg::FC_RD_INPUT, A_ST, 2);
    wr(dev_addr, A_CFG, 1);
    wr(dev_addr, A_CFG + 16'd78, 1);
    wr(8'h00, A_CFG + 16'd5, 1);
    wr(dev_addr, A_CFG + 16'd10, 4);
    wr(8'h00, A_CFG + 16'd20, 3);
    rd(mbsda_pkg::FC_RD_HOLD, A_CFG, 79);
    for (i = 0; i < 79; i += 13) begin
      @(negedge mclk);
      cfg_rd_index = 7'(i);
      @(negedge mclk);
      cmp_word(cfg_rd_word, mdl[A_CFG + 16'(i)]);
    end
    exc(8'h05, A_VI, 16'h0001, mbsda_pkg::EXC_ILL_FUNC);
    exc(mbsda_pkg::FC_DIAG, 16'h0000, 16'h0001, mbsda_pkg::EXC_ILL_FUNC);
    exc(mbsda_pkg::FC_WR_SINGLE, A_VI, 16'h0001, mbsda_pkg::EXC_ILL_ADDR);
    exc(mbsda_pkg::FC_WR_SINGLE, A_PW + 16'd3, 16'h0001, mbsda_pkg::EXC_ILL_ADDR);
    exc(mbsda_pkg::FC_WR_SINGLE, A_ST, 16'h0001, mbsda_pkg::EXC_ILL_ADDR);
    exc(mbsda_pkg::FC_WR_MULTI, A_PW, 16'h0002, mbsda_pkg::EXC_ILL_ADDR);
    exc(mbsda_pkg::FC_RD_HOLD, A_VI + 16'd20, 16'h0008, mbsda_pkg::EXC_ILL_ADDR);
    exc(mbsda_pkg::FC_RD_HOLD, A_VI, 16'h0000, mbsda_pkg::EXC_ILL_VALUE);
    rd(mbsda_pkg::FC_RD_HOLD, A_VI, 24);
    wq = {};
    go(dev_addr, mbsda_pkg::FC_DIAG, 16'h0000, 16'h0000, 16'hA5C3, 1'b1);
    chk(mbsda_pkg::FC_DIAG, {16'h0000, 16'hA5C3});
    go(dev_addr + 8'h01, mbsda_pkg::FC_RD_HOLD, A_VI, 16'h0002, 16'h0000, 1'b0);
    rd(mbsda_pkg::FC_RD_HOLD, A_ST, 2);
    end_sim();
  end
endmodule

`default_nettype wire
